// file: rtl/sbr_params.svh
/*
  Constants of the SPI register bank: frame layout, register addresses,
  field masks and reset values. Assumes nothing; definitions only.
*/
`ifndef SBR_PARAMS_SVH
`define SBR_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define SBR_FRAME_BITS 16
`define SBR_BYTE_BITS 8
`define SBR_ADDR_BITS 7
`define SBR_ACC_BIT 7
`define SBR_NUM_CTL 12
`define SBR_NUM_ST 10

// ----------------------------------------------------------------------
// control register addresses
// ----------------------------------------------------------------------
`define SBR_A_MODE_SUPPLY 7'h01
`define SBR_A_HW_CFG_A 7'h02
`define SBR_A_WATCHDOG 7'h03
`define SBR_A_CAN0_CTL 7'h04
`define SBR_A_WAKE_TIMER 7'h06
`define SBR_A_WAKE_EN 7'h07
`define SBR_A_WAKE_PULL 7'h08
`define SBR_A_CAN12_CTL 7'h0A
`define SBR_A_CAN3_CTL 7'h0B
`define SBR_A_TIMER_PER 7'h0C
`define SBR_A_HW_CFG_B 7'h0E
`define SBR_A_SCRATCH 7'h1E

// ----------------------------------------------------------------------
// status register addresses
// ----------------------------------------------------------------------
`define SBR_A_SUPPLY_B 7'h40
`define SBR_A_SUPPLY_A 7'h41
`define SBR_A_THERMAL 7'h42
`define SBR_A_DEVICE 7'h43
`define SBR_A_CAN0_ST 7'h44
`define SBR_A_WAKE_SRC_A 7'h46
`define SBR_A_WAKE_LEVEL 7'h48
`define SBR_A_WAKE_SRC_B 7'h49
`define SBR_A_CAN12_ST 7'h4A
`define SBR_A_CAN3_ST 7'h4B
`define SBR_A_CONVERTER 7'h4C
`define SBR_A_FAMILY_ID 7'h7E

// ----------------------------------------------------------------------
// writable bits (rw and rwh) of each control register
// ----------------------------------------------------------------------
`define SBR_WM_MODE_SUPPLY 8'hE7
`define SBR_WM_HW_CFG_A 8'h7B
`define SBR_WM_WATCHDOG 8'hFF
`define SBR_WM_CAN0_CTL 8'h03
`define SBR_WM_WAKE_TIMER 8'h75
`define SBR_WM_WAKE_EN 8'h01
`define SBR_WM_WAKE_PULL 8'h03
`define SBR_WM_CAN12_CTL 8'hDB
`define SBR_WM_CAN3_CTL 8'h1B
`define SBR_WM_TIMER_PER 8'h07
`define SBR_WM_HW_CFG_B 8'h6F
`define SBR_WM_SCRATCH 8'hFF

// ----------------------------------------------------------------------
// hardware-changeable bits, restart keep masks, reset values
// ----------------------------------------------------------------------
`define SBR_HM_MODE_SUPPLY 8'hC4
`define SBR_HM_HW_CFG_A 8'h32
`define SBR_HM_NONE 8'h00
`define SBR_KEEP_MODE_SUPPLY 8'h23
`define SBR_KEEP_HW_CFG_A 8'h5F
`define SBR_KEEP_ALL 8'hFF
`define SBR_CTL_POR 8'h00
`define SBR_ST_POR 8'h00
`define SBR_MODE_LSB 6
`define SBR_MODE_SOFT_RESET 2'h3

// ----------------------------------------------------------------------
// implemented bits of each status register
// ----------------------------------------------------------------------
`define SBR_VM_SUPPLY_B 8'hDF
`define SBR_VM_SUPPLY_A 8'h87
`define SBR_VM_THERMAL 8'h67
`define SBR_VM_DEVICE 8'hCF
`define SBR_VM_CAN0_ST 8'h07
`define SBR_VM_WAKE_SRC_A 8'hB1
`define SBR_VM_WAKE_SRC_B 8'h87
`define SBR_VM_CAN12_ST 8'h33
`define SBR_VM_CAN3_ST 8'h03
`define SBR_VM_CONVERTER 8'hE6
`define SBR_VM_WAKE_LEVEL 8'hF9

`endif

// file: rtl/sbr_pkg.sv
/*
  Types shared by the SPI register bank modules.
  Assumes sbr_params.svh is on the include path.
*/
`include "sbr_params.svh"

package sbr_pkg;

  typedef logic [`SBR_BYTE_BITS-1:0] sbr_byte_t;
  typedef sbr_byte_t [`SBR_NUM_CTL-1:0] sbr_ctl_bank_t;
  typedef sbr_byte_t [`SBR_NUM_ST-1:0] sbr_st_bank_t;

  // spi pins as sampled, chip select active low
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } sbr_spi_pins_t;

  // hardware update of rwh control bits
  typedef struct packed {
    logic [`SBR_NUM_CTL-1:0] we;
    sbr_ctl_bank_t d;
  } sbr_hw_upd_t;

endpackage : sbr_pkg

// file: rtl/sbr_sync.sv
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit may be sampled on its own; no bus coherency.
*/
`timescale 1ns/1ps

module sbr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  if (W < 1) $error("sbr_sync: W must be at least 1");

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      meta_r <= RST;
      q_r <= RST;
    end
    else
    begin
      meta_r <= d_i;
      q_r <= meta_r;
    end

  assign q_o = q_r;

endmodule : sbr_sync

// file: rtl/sbr_rc_reg.sv
/*
  One read/clear status register: hardware sets bits, a clearing
  access drops them. Assumes set and clear come from sys_clk logic.
*/
`timescale 1ns/1ps

module sbr_rc_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] POR = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic soft_i,
  input wire logic clr_i,
  input wire logic [W-1:0] set_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  if (W < 1) $error("sbr_rc_reg: W must be at least 1");

  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    q_nxt = q_r;
    if (soft_i)
      q_nxt = POR;
    else if (clr_i)
      q_nxt = '0;
    q_nxt = (q_nxt | set_i) & VALID;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      q_r <= POR & VALID;
    else
      q_r <= q_nxt;

  assign q_o = q_r;

  clear_drops_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R13]
    clr_i && !soft_i && set_i == '0 |=> q_r == '0)
    else $error("status byte not cleared");
  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R9]
    (set_i & VALID) != '0 |=> (q_r & $past(set_i) & VALID) == ($past(set_i) & VALID))
    else $error("status event lost");

endmodule : sbr_rc_reg

// file: rtl/sbr_spi_regs.sv
/*
  SPI register bank: 16-bit slave frames, twelve control registers,
  ten read/clear status registers, wake level and identity bytes.
  Assumes sys_clk_i is far faster than the SPI clock (about 8x or more),
  that restart_i, dev_ignore_i and the hardware update inputs come from
  logic on sys_clk_i, and that the SPI pins are asynchronous.
*/
`timescale 1ns/1ps
`include "sbr_params.svh"

// How it works
// [R1] frame is 16 bits: address, access bit, data
// [R2] data bits D0..D7 sit at frame 8..15
// [R3] access bit zero: read only, nothing changes
// [R4] access bit one: whole control byte written
// [R5] power-on or soft reset loads reset values
// [R6] restart keeps marked bits, clears the others
// [R7] read-only and reserved bits ignore writes
// [R8] rw bits store writes, hardware leaves them
// [R9] rwh bits may also change by hardware
// [R10] master clears control bits itself
// [R11] twelve control, ten status, level, identity
// [R12] low addresses control, high addresses status
// [R13] access bit one clears status after reporting
// [R14] frames ignored in restart, sleep, fail-safe
// [R15] clearing level or identity changes nothing
// [R16] unmapped address reads zero, changes nothing
module sbr_spi_regs #(
  parameter logic [7:0] FAMILY_PRODUCT_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // spi pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // device state
  input wire logic dev_ignore_i,
  input wire logic restart_i,
  input wire sbr_pkg::sbr_hw_upd_t hw_upd_i,
  input wire sbr_pkg::sbr_st_bank_t st_set_i,
  input wire logic [7:0] wake_level_i,
  // register contents
  output sbr_pkg::sbr_ctl_bank_t ctl_o,
  output logic soft_reset_o
);
  import sbr_pkg::*;

  // ----------------------------------------------------------------------
  // register tables
  // ----------------------------------------------------------------------
  localparam int NC = `SBR_NUM_CTL; // see [R11]
  localparam int NS = `SBR_NUM_ST;
  localparam int IW = 4;
  localparam logic [4:0] FRAME_CNT = 5'(`SBR_FRAME_BITS);
  localparam logic [4:0] OVER_CNT = 5'(`SBR_FRAME_BITS + 1);
  localparam logic [4:0] ADDR_DONE = 5'(`SBR_ACC_BIT);
  localparam logic [6:0] CTL_ADDR [NC] = '{`SBR_A_MODE_SUPPLY, `SBR_A_HW_CFG_A,
    `SBR_A_WATCHDOG, `SBR_A_CAN0_CTL, `SBR_A_WAKE_TIMER, `SBR_A_WAKE_EN,
    `SBR_A_WAKE_PULL, `SBR_A_CAN12_CTL, `SBR_A_CAN3_CTL, `SBR_A_TIMER_PER,
    `SBR_A_HW_CFG_B, `SBR_A_SCRATCH};
  localparam logic [7:0] WMASK [NC] = '{`SBR_WM_MODE_SUPPLY, `SBR_WM_HW_CFG_A,
    `SBR_WM_WATCHDOG, `SBR_WM_CAN0_CTL, `SBR_WM_WAKE_TIMER, `SBR_WM_WAKE_EN,
    `SBR_WM_WAKE_PULL, `SBR_WM_CAN12_CTL, `SBR_WM_CAN3_CTL, `SBR_WM_TIMER_PER,
    `SBR_WM_HW_CFG_B, `SBR_WM_SCRATCH};
  localparam logic [7:0] HMASK [NC] = '{`SBR_HM_MODE_SUPPLY, `SBR_HM_HW_CFG_A,
    `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE,
    `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE, `SBR_HM_NONE};
  localparam logic [7:0] KEEP [NC] = '{`SBR_KEEP_MODE_SUPPLY, `SBR_KEEP_HW_CFG_A,
    `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL,
    `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL, `SBR_KEEP_ALL};
  localparam logic [6:0] ST_ADDR [NS] = '{`SBR_A_SUPPLY_B, `SBR_A_SUPPLY_A,
    `SBR_A_THERMAL, `SBR_A_DEVICE, `SBR_A_CAN0_ST, `SBR_A_WAKE_SRC_A,
    `SBR_A_WAKE_SRC_B, `SBR_A_CAN12_ST, `SBR_A_CAN3_ST, `SBR_A_CONVERTER};
  localparam logic [7:0] VMASK [NS] = '{`SBR_VM_SUPPLY_B, `SBR_VM_SUPPLY_A,
    `SBR_VM_THERMAL, `SBR_VM_DEVICE, `SBR_VM_CAN0_ST, `SBR_VM_WAKE_SRC_A,
    `SBR_VM_WAKE_SRC_B, `SBR_VM_CAN12_ST, `SBR_VM_CAN3_ST, `SBR_VM_CONVERTER};

  if (`SBR_FRAME_BITS != 2 * `SBR_BYTE_BITS || NC > 2 ** IW || NS > 2 ** IW)
    $error("sbr_spi_regs: frame or table size not supported");

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  sbr_spi_pins_t pin_s;
  logic [7:0] wake_lvl_s;

  sbr_sync #(.W(3), .RST(3'h4)) u_pin_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({spi_cs_n_i, spi_sclk_i, spi_sdi_i}),
    .q_o(pin_s)
  );

  sbr_sync #(.W(8)) u_lvl_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(wake_level_i),
    .q_o(wake_lvl_s)
  );

  // ----------------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------------
  logic sclk_q_r;
  logic cs_q_r;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] rx_r, rx_nxt;
  sbr_byte_t tx_r, tx_nxt;
  logic sdo_r, sdo_nxt;
  logic ign_r, ign_nxt;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic commit, wr;
  logic [6:0] addr;
  sbr_byte_t wdata, rd_data, sif;
  sbr_ctl_bank_t ctl_r, ctl_nxt;
  sbr_st_bank_t st_q;

  assign sclk_rise = pin_s.sclk & ~sclk_q_r;
  assign sclk_fall = ~pin_s.sclk & sclk_q_r;
  assign cs_fall = cs_q_r & ~pin_s.cs_n;
  assign cs_rise = ~cs_q_r & pin_s.cs_n;
  assign addr = rx_r[`SBR_ADDR_BITS-1:0];
  assign wr = rx_r[`SBR_ACC_BIT];
  assign wdata = rx_r[`SBR_FRAME_BITS-1:`SBR_BYTE_BITS]; // see [R2]
  // short, long and ignored frames are dropped at chip select release
  assign commit = cs_rise && bit_cnt_r == FRAME_CNT && !ign_r && !dev_ignore_i; // see [R1] [R14]

  // first byte out: one flag per non-empty status group
  assign sif = {|st_q[9], |st_q[6], |st_q[5], |(st_q[7] | st_q[8]),
                |st_q[4], |st_q[3], |st_q[2], |(st_q[0] | st_q[1])};

  // bits go out lsb first; sdo moves on rising, sdi sampled on falling
  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    sdo_nxt = sdo_r;
    ign_nxt = ign_r;
    if (cs_fall)
    begin
      bit_cnt_nxt = '0;
      rx_nxt = '0;
      tx_nxt = sif;
      ign_nxt = dev_ignore_i; // see [R14]
    end
    else if (!pin_s.cs_n)
    begin
      if (sclk_rise && bit_cnt_r < FRAME_CNT)
      begin
        sdo_nxt = tx_r[0];
        tx_nxt = tx_r >> 1;
      end
      if (sclk_fall)
      begin
        if (bit_cnt_r < FRAME_CNT)
        begin
          rx_nxt[bit_cnt_r[3:0]] = pin_s.sdi; // see [R1]
          bit_cnt_nxt = bit_cnt_r + 5'd1;
        end
        else
          bit_cnt_nxt = OVER_CNT;
        // address complete: second byte reports content before any change
        if (bit_cnt_r == ADDR_DONE)
          tx_nxt = rd_data;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      bit_cnt_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      sdo_r <= 1'b0;
      ign_r <= 1'b0;
    end
    else
    begin
      sclk_q_r <= pin_s.sclk;
      cs_q_r <= pin_s.cs_n;
      bit_cnt_r <= bit_cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      sdo_r <= sdo_nxt;
      ign_r <= ign_nxt;
    end

  assign spi_sdo_o = sdo_r;
  assign spi_sdo_oe_o = ~pin_s.cs_n;

  // ----------------------------------------------------------------------
  // address decode and read data
  // ----------------------------------------------------------------------
  logic ctl_hit, st_hit, lvl_hit, id_hit;
  logic [IW-1:0] ctl_idx, st_idx;

  always_comb
  begin
    ctl_hit = 1'b0;
    ctl_idx = '0;
    st_hit = 1'b0;
    st_idx = '0;
    for (int i = 0; i < NC; i++)
      if (addr == CTL_ADDR[i]) // see [R12]
      begin
        ctl_hit = 1'b1;
        ctl_idx = IW'(i);
      end
    for (int i = 0; i < NS; i++)
      if (addr == ST_ADDR[i]) // see [R12]
      begin
        st_hit = 1'b1;
        st_idx = IW'(i);
      end
    lvl_hit = addr == `SBR_A_WAKE_LEVEL;
    id_hit = addr == `SBR_A_FAMILY_ID;
    rd_data = '0; // see [R16]
    if (ctl_hit)
      rd_data = ctl_r[ctl_idx];
    else if (st_hit)
      rd_data = st_q[st_idx];
    else if (lvl_hit)
      rd_data = wake_lvl_s & `SBR_VM_WAKE_LEVEL; // see [R7]
    else if (id_hit)
      rd_data = FAMILY_PRODUCT_ID;
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic soft_r, soft_nxt;

  always_comb
  begin
    ctl_nxt = ctl_r;
    soft_nxt = 1'b0;
    if (soft_r)
      ctl_nxt = {NC{`SBR_CTL_POR}}; // see [R5]
    else
    begin
      if (restart_i)
      begin
        for (int i = 0; i < NC; i++)
          ctl_nxt[i] = ctl_r[i] & KEEP[i]; // see [R6]
      end
      else if (commit && wr && ctl_hit) // see [R3] [R4]
      begin
        // only writable bits take data; reserved bits hold zero
        ctl_nxt[ctl_idx] = (ctl_r[ctl_idx] & ~WMASK[ctl_idx]) |
                           (wdata & WMASK[ctl_idx]); // see [R4] [R7] [R8]
        if (ctl_idx == '0 &&
            wdata[`SBR_MODE_LSB+:2] == `SBR_MODE_SOFT_RESET)
          soft_nxt = 1'b1; // see [R5]
      end
      // hardware writes only the rwh bits and wins over spi
      for (int i = 0; i < NC; i++)
        if (hw_upd_i.we[i])
          ctl_nxt[i] = (ctl_nxt[i] & ~HMASK[i]) | (hw_upd_i.d[i] & HMASK[i]); // see [R9]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ctl_r <= {NC{`SBR_CTL_POR}}; // see [R5]
      soft_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      soft_r <= soft_nxt;
    end

  assign ctl_o = ctl_r;
  assign soft_reset_o = soft_r;

  // ----------------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------------
  // a clear lands at frame end, after the byte went out unchanged
  for (genvar g = 0; g < NS; g++)
  begin : g_st
    sbr_rc_reg #(.W(8), .VALID(VMASK[g]), .POR(`SBR_ST_POR)) u_st (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .soft_i(soft_r),
      .clr_i(commit && wr && st_hit && st_idx == IW'(g)), // see [R13] [R15]
      .set_i(st_set_i[g]),
      .q_o(st_q[g])
    );
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic quiet;
  logic [IW-1:0] hx_idx_r;
  sbr_byte_t hx_d_r;
  sbr_ctl_bank_t prev_ctl_r;
  logic resv_bad;

  assign quiet = !restart_i && !soft_r && hw_upd_i.we == '0;

  always_comb
  begin
    resv_bad = 1'b0;
    for (int i = 0; i < NC; i++)
      resv_bad = resv_bad | ((ctl_r[i] & ~(WMASK[i] | HMASK[i])) != '0);
  end

  always_ff @(posedge sys_clk_i)
  begin
    hx_idx_r <= ctl_idx;
    hx_d_r <= wdata;
    prev_ctl_r <= ctl_r;
  end

  frame_len_a: assert property (cs_rise && bit_cnt_r != FRAME_CNT && quiet // see [R1]
    |=> ctl_r == prev_ctl_r) else $error("partial frame changed a register");
  read_only_a: assert property (commit && !wr && quiet // see [R3]
    |=> ctl_r == prev_ctl_r) else $error("read access changed a register");
  write_byte_a: assert property (commit && wr && ctl_hit && quiet // see [R4]
    |=> (ctl_r[hx_idx_r] & WMASK[hx_idx_r]) == (hx_d_r & WMASK[hx_idx_r]))
    else $error("write data not stored");
  soft_reset_a: assert property (commit && wr && ctl_hit && ctl_idx == '0 && quiet // see [R5]
    && wdata[`SBR_MODE_LSB+:2] == `SBR_MODE_SOFT_RESET
    |=> soft_r ##1 ctl_r == {NC{`SBR_CTL_POR}}) else $error("soft reset missed");
  restart_a: assert property (restart_i && !soft_r && hw_upd_i.we == '0 // see [R6]
    |=> (ctl_r[0] == (prev_ctl_r[0] & KEEP[0])) && (ctl_r[1] == (prev_ctl_r[1] & KEEP[1])))
    else $error("restart value wrong");
  reserved_zero_a: assert property (!resv_bad) // see [R7]
    else $error("reserved control bit set");
  ignore_frame_a: assert property (cs_rise && (ign_r || dev_ignore_i) && quiet // see [R14]
    |=> ctl_r == prev_ctl_r) else $error("frame taken while ignoring");
  unmapped_zero_a: assert property (sclk_fall && !pin_s.cs_n && bit_cnt_r == ADDR_DONE // see [R16]
    && !ctl_hit && !st_hit && !lvl_hit && !id_hit |=> tx_r == '0)
    else $error("unmapped address read non-zero");
  id_fixed_a: assert property (sclk_fall && !pin_s.cs_n && bit_cnt_r == ADDR_DONE // see [R15]
    && id_hit |=> tx_r == FAMILY_PRODUCT_ID) else $error("identity byte wrong");

  write_cv: cover property (commit && wr && ctl_hit);
  clear_cv: cover property (commit && wr && st_hit && st_q[st_idx] != '0);
  ignored_cv: cover property (cs_rise && bit_cnt_r == FRAME_CNT && dev_ignore_i);
  soft_cv: cover property (soft_r);

endmodule : sbr_spi_regs

// file: bench/sbr_spi_master.sv
/*
  Behavioural SPI master standing in for the microcontroller.
  Assumes the bank samples on falling sclk (mode 1, lsb first) and that
  sys_clk_i runs eight times faster than the link clock.
*/
`timescale 1ns/1ps

module sbr_spi_master (
  // clock
  input wire logic sys_clk_i,
  // spi pins
  input wire logic spi_sdo_i,
  output logic spi_cs_n_o,
  output logic spi_sclk_o,
  output logic spi_sdi_o
);
  initial
  begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_sdi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wait_clk

  // ----------------------------------------------------------------------
  // one frame; sclk period 8 sys clocks, idle low between frames
  // ----------------------------------------------------------------------
  task automatic xfer(input logic [6:0] addr, input logic acc, input logic [7:0] data,
                      input int nbits, output logic [15:0] rx);
    logic [15:0] frame;
    frame = {data, acc, addr};
    rx = '0;
    @(posedge sys_clk_i);
    spi_cs_n_o <= 1'b0;
    wait_clk(4);
    for (int k = 0; k < nbits; k++)
    begin
      spi_sclk_o <= 1'b1;
      spi_sdi_o <= frame[k];
      wait_clk(4);
      spi_sclk_o <= 1'b0;
      // sample late in the low phase: sdo lags the rising edge by the sync
      wait_clk(3);
      rx[k] = spi_sdo_i;
      wait_clk(1);
    end
    wait_clk(3);
    spi_cs_n_o <= 1'b1;
    // released line shows no stale bit
    spi_sdi_o <= ~spi_sdi_o;
    wait_clk(8);
  endtask : xfer
endmodule : sbr_spi_master

// file: bench/tb_spi_register_map_access.sv
/*
  Self-checking bench of the SPI register bank.
  Assumes the design package and header are compiled first.
*/
`timescale 1ns/1ps

`define CHECK_EQ(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_spi_register_map_access;
  import sbr_pkg::*;

  typedef struct packed {
    logic [6:0] addr;
    logic acc;
    logic [7:0] data;
    logic [7:0] exp;
  } sbr_row_t;

  // ----------------------------------------------------------------------
  // rows: expected byte is the content before this frame's write
  // ----------------------------------------------------------------------
  localparam sbr_row_t ROWS [15] = '{
    '{7'h03, 1'b1, 8'hA5, 8'h00},
    '{7'h03, 1'b0, 8'hFF, 8'hA5},
    '{7'h03, 1'b0, 8'h00, 8'hA5},
    '{7'h01, 1'b1, 8'h3F, 8'h00},
    '{7'h01, 1'b0, 8'h00, 8'h27},
    '{7'h1E, 1'b1, 8'h5C, 8'h00},
    '{7'h1E, 1'b0, 8'h00, 8'h5C},
    '{7'h04, 1'b1, 8'hFF, 8'h00},
    '{7'h04, 1'b0, 8'h00, 8'h03},
    '{7'h05, 1'b1, 8'h77, 8'h00},
    '{7'h05, 1'b0, 8'h00, 8'h00},
    '{7'h7E, 1'b1, 8'h00, 8'h5A},
    '{7'h7E, 1'b0, 8'h00, 8'h5A},
    '{7'h0C, 1'b1, 8'hFF, 8'h00},
    '{7'h0C, 1'b0, 8'h00, 8'h07}
  };

  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic dev_ignore = 1'b0;
  logic restart = 1'b0;
  sbr_hw_upd_t hw_upd = '0;
  sbr_st_bank_t st_set = '0;
  logic [7:0] wake_level = 8'h00;
  sbr_ctl_bank_t ctl;
  logic soft_reset;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_soft = 0;
  logic [2:0] cs_hist = 3'h7;

  always #10 sys_clk_i = ~sys_clk_i;

  sbr_spi_regs sbr_spi_regs_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .spi_cs_n_i(spi_cs_n), .spi_sclk_i(spi_sclk), .spi_sdi_i(spi_sdi),
    .spi_sdo_o(spi_sdo), .spi_sdo_oe_o(spi_sdo_oe),
    .dev_ignore_i(dev_ignore), .restart_i(restart), .hw_upd_i(hw_upd),
    .st_set_i(st_set), .wake_level_i(wake_level),
    .ctl_o(ctl), .soft_reset_o(soft_reset)
  );

  sbr_spi_master sbr_spi_master_inst (
    .sys_clk_i(sys_clk_i), .spi_sdo_i(spi_sdo),
    .spi_cs_n_o(spi_cs_n), .spi_sclk_o(spi_sclk), .spi_sdi_o(spi_sdi)
  );

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // one full frame and a check of both answer bytes
  // ----------------------------------------------------------------------
  task automatic run(input logic [6:0] a, input logic acc, input logic [7:0] d,
                     input logic [7:0] e, input logic [7:0] s);
    logic [15:0] rx;
    sbr_spi_master_inst.xfer(a, acc, d, 16, rx);
    `CHECK_EQ(rx[15:8], e)
    `CHECK_EQ(rx[7:0], s)
  endtask : run

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle

  always @(posedge sys_clk_i)
  begin
    if (soft_reset === 1'b1)
      n_soft++;
    cycles++;
    // frames run about 150 cycles; 28 frames fit well inside
    if (cycles == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // oe follows the synced chip select, two clocks behind the pin
  always @(posedge sys_clk_i)
  begin
    cs_hist <= {cs_hist[1:0], spi_cs_n};
    if (rst_n_i)
      `CHECK_EQ(spi_sdo_oe, ~cs_hist[1])
  end

  initial
  begin
    logic [15:0] rx;
    settle(4);
    `CHECK_EQ(ctl, '0)
    `CHECK_EQ(spi_sdo_oe, 1'b0)
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    foreach (ROWS[i])
      run(ROWS[i].addr, ROWS[i].acc, ROWS[i].data, ROWS[i].exp, 8'h00);
    `CHECK_EQ(ctl[2], 8'hA5)
    $display("row table done");
    // frames refused while ignoring, and a short frame
    @(posedge sys_clk_i);
    dev_ignore <= 1'b1;
    run(7'h03, 1'b1, 8'h00, 8'hA5, 8'h00);
    dev_ignore <= 1'b0;
    sbr_spi_master_inst.xfer(7'h03, 1'b1, 8'h00, 15, rx);
    run(7'h03, 1'b0, 8'h00, 8'hA5, 8'h00);
    $display("refused frames done");
    // status report, then clear after reporting
    @(posedge sys_clk_i);
    st_set[1] <= 8'h81;
    @(posedge sys_clk_i);
    st_set <= '0;
    run(7'h41, 1'b0, 8'h00, 8'h81, 8'h01);
    run(7'h41, 1'b1, 8'h00, 8'h81, 8'h01);
    run(7'h41, 1'b0, 8'h00, 8'h00, 8'h00);
    wake_level <= 8'hFF;
    run(7'h48, 1'b1, 8'h00, 8'hF9, 8'h00);
    run(7'h48, 1'b0, 8'h00, 8'hF9, 8'h00);
    $display("status done");
    // restart keeps marked bits, hardware touches rwh bits only
    @(posedge sys_clk_i);
    restart <= 1'b1;
    @(posedge sys_clk_i);
    restart <= 1'b0;
    settle(1);
    `CHECK_EQ(ctl[0], 8'h23)
    `CHECK_EQ(ctl[2], 8'hA5)
    @(posedge sys_clk_i);
    hw_upd.we[0] <= 1'b1;
    hw_upd.d[0] <= 8'h3C;
    @(posedge sys_clk_i);
    hw_upd <= '0;
    settle(1);
    `CHECK_EQ(ctl[0], 8'h27)
    run(7'h1E, 1'b1, 8'h00, 8'h5C, 8'h00);
    `CHECK_EQ(ctl[11], 8'h00)
    $display("restart and hardware done");
    // soft reset through the mode field
    run(7'h01, 1'b1, 8'hC0, 8'h27, 8'h00);
    settle(2);
    `CHECK_EQ(n_soft, 1)
    `CHECK_EQ(ctl, '0)
    run(7'h03, 1'b0, 8'h00, 8'h00, 8'h00);
    $display("soft reset done");
    // reset in mid-run drops a written byte
    run(7'h03, 1'b1, 8'h3C, 8'h00, 8'h00);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    settle(2);
    `CHECK_EQ(ctl, '0)
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    run(7'h03, 1'b0, 8'h00, 8'h00, 8'h00);
    $display("mid-run reset done");
    final_report();
  end
endmodule : tb_spi_register_map_access
